// [bank_regs.sv]
// Byte-wide gain configuration, bank switching and counter control decoding.
`timescale 1ns/1ns
`include "bank_regs_cfg.svh"
// How it works
// [RULE_01] Key nibbles F, 5, D written to offset B select the indexed array.
// [RULE_02] Key nibbles 3, B, A written to offset B select the counter bank.
// [RULE_03] Any other nibble sequence leaves the selected bank unchanged.
// [RULE_04] Reset selects the counter bank, showing the original layout.
// [RULE_05] Bit 7 of a config read shows the bank; only in enhanced mode.
// [RULE_06] Config write: bits 7..4 key, 3 range, 2 unipolar, 1..0 gain.
// [RULE_07] Config read: bank in bit 7, zeros in 6..4, gain setting in 3..0.
// [RULE_08] One gain setting for all inputs, decoded to nine spans.
// [RULE_09] Samples reach the host as 12-bit unsigned codes 0 to 4095.
// [RULE_10] Counter bank: counter data ports at offsets C, D, E, read and write.
// [RULE_11] Counter bank: write-only control word at offset F.
// [RULE_12] Indexed bank: counter ports and control word at indices 68 to 71.
// [RULE_13] Control bits 7..6 pick counter 0, 1, 2 or read-back.
// [RULE_14] Control bits 5..4 pick latch, low, high or low-then-high access.
// [RULE_15] Control bits 3..1 pick the counting mode, X10 and X11 folded.
// [RULE_16] Control bit 0 picks four-decade decimal or 16-bit binary count.
// [RULE_17] Indexed bank: offsets C and D are the data port, word at C.
// [RULE_18] A repeated first key nibble stays at the first step.
module bank_regs
    import bank_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic word_n,
    input wire logic enhanced_mode,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output logic rdata_oe,
    input wire logic [2:0][7:0] ctr_rd_byte,
    input wire logic [15:0] sample_raw,
    input wire logic sample_valid,
    output logic [11:0] sample_code,
    output logic sample_code_valid,
    output gain_cfg_t gain_cfg,
    output span_t span,
    output bank_t active_bank_flag,
    output ctr_cfg_t [2:0] counter_cfg,
    output logic [2:0] ctr_cfg_load,
    output logic [2:0] ctr_latch,
    output logic readback_cmd,
    output logic [7:0] readback_byte,
    output logic [2:0] ctr_wr,
    output logic [2:0][7:0] ctr_wdata,
    output logic [2:0] ctr_rd
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    bus_pins_t pin_now;
    bus_pins_t s1;
    bus_pins_t s2;
    bus_pins_t s3;
    logic rd_lvl;
    logic wr_lvl;
    logic enh_lvl;
    logic rd_ev;
    logic wr_ev;
    logic rd_end;

    assign pin_now = {ior_n, iow_n, word_n, enhanced_mode, addr, wdata};

    // Address and data travel with the strobes so all arrive aligned.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1 <= `PINS_IDLE;
            s2 <= `PINS_IDLE;
            s3 <= `PINS_IDLE;
        end else begin
            s1 <= pin_now;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_lvl <= 1'b1;
            wr_lvl <= 1'b1;
            enh_lvl <= 1'b0;
        end else begin
            if (s2.ior_n == s3.ior_n) rd_lvl <= s3.ior_n;
            if (s2.iow_n == s3.iow_n) wr_lvl <= s3.iow_n;
            if (s2.enhanced_mode == s3.enhanced_mode) enh_lvl <= s3.enhanced_mode;
        end
    end

    assign rd_ev = (s2.ior_n == s3.ior_n) && !s3.ior_n && rd_lvl;
    assign wr_ev = (s2.iow_n == s3.iow_n) && !s3.iow_n && wr_lvl;
    assign rd_end = (s2.ior_n == s3.ior_n) && s3.ior_n;

    // ------------------------------------------------------------------------
    // Bank selection
    // ------------------------------------------------------------------------
    logic cfg_wr;

    assign cfg_wr = wr_ev && s3.addr == `OFS_GAIN_CFG;

    bank_key_detect u_key (
        .mclk(mclk),
        .resetn(resetn),
        .enable(enh_lvl), // [RULE_05]
        .key_write(cfg_wr),
        .bank_key_nibble(s3.wdata[`CFG_KEY_HI:`CFG_KEY_LO]), // [RULE_06]
        .active_bank_flag(active_bank_flag)
    );

    // ------------------------------------------------------------------------
    // Upper four offsets mapped onto indices
    // ------------------------------------------------------------------------
    logic [7:0] ptr;
    logic [7:0] idx0;
    logic [7:0] idx1;
    logic two;
    logic port_hit;
    logic ptr_hit;
    logic cw_hit;
    logic [7:0] cw_byte;
    logic [7:0] idx_mem [0:`IDX_MEM_DEPTH-1];

    // In the counter bank, offset C..F is treated as index 68..71.
    always_comb begin
        idx0 = 8'h00;
        idx1 = ptr + 8'h01;
        two = 1'b0;
        port_hit = 1'b0;
        ptr_hit = 1'b0;
        if (s3.addr >= `OFS_CTR0) begin
            if (active_bank_flag == BANK_COUNTER) begin
                port_hit = 1'b1;
                idx0 = `IDX_CTR0 + {6'h00, s3.addr[1:0]}; // [RULE_10] [RULE_11]
            end else if (s3.addr == `OFS_CTR0) begin
                port_hit = 1'b1;
                idx0 = ptr;
                two = !s3.word_n; // [RULE_17]
            end else if (s3.addr == `OFS_CTR1) begin
                port_hit = 1'b1;
                idx0 = ptr + 8'h01; // [RULE_17]
            end else if (s3.addr == `OFS_PTR) begin
                ptr_hit = 1'b1;
            end
        end
        cw_hit = port_hit && (idx0 == `IDX_CTRL || (two && idx1 == `IDX_CTRL));
        cw_byte = (two && idx1 == `IDX_CTRL) ? s3.wdata[15:8] : s3.wdata[7:0];
    end

    // One-hot counter select for an index in 68..70.
    function automatic logic [2:0] ctr_hit(input logic [7:0] i);
        ctr_hit = 3'h0;
        if (i >= `IDX_CTR0 && i < `IDX_CTRL) ctr_hit = 3'h1 << (i - `IDX_CTR0); // [RULE_12]
    endfunction

    logic [2:0] hit0;
    logic [2:0] hit1;

    assign hit0 = ctr_hit(idx0);
    assign hit1 = ctr_hit(idx1);

    function automatic logic mem_ok(input logic [7:0] i);
        mem_ok = !i[7] && (i < `IDX_CTR0 || i > `IDX_CTRL);
    endfunction

    // The control word is write-only, so index 71 reads as zero.
    function automatic logic [7:0] byte_of(input logic [7:0] i);
        logic [2:0] hit;
        hit = ctr_hit(i);
        byte_of = 8'h00;
        for (int k = 0; k < 3; k++) begin
            if (hit[k]) byte_of = ctr_rd_byte[k];
        end
        if (mem_ok(i)) byte_of = idx_mem[i[6:0]];
    endfunction

    // Modes X10 and X11 are folded onto their canonical codes.
    function automatic ctr_mode_t norm_mode(input logic [2:0] m);
        if (m[1:0] == 2'b10) norm_mode = MODE_RATE;
        else if (m[1:0] == 2'b11) norm_mode = MODE_SQUARE;
        else norm_mode = ctr_mode_t'(m);
    endfunction

    // ------------------------------------------------------------------------
    // Gain configuration
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gain_cfg <= `GAIN_CFG_RST;
        end else if (cfg_wr) begin
            gain_cfg <= s3.wdata[`CFG_LOW_HI:0]; // [RULE_06]
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            span <= SPAN_BI_5;
        end else if (gain_cfg.range) begin
            span <= SPAN_BI_10; // [RULE_08]
        end else if (gain_cfg.unipolar_select) begin
            span <= span_t'(4'h5 + {2'b00, gain_cfg.gain_code});
        end else begin
            span <= span_t'(4'h1 + {2'b00, gain_cfg.gain_code});
        end
    end

    // Inverting the sign bit gives offset binary, so the top twelve bits give 0..4095.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sample_code <= 12'h000;
            sample_code_valid <= 1'b0;
        end else begin
            sample_code_valid <= sample_valid;
            if (sample_valid) sample_code <= {~sample_raw[15], sample_raw[14:4]}; // [RULE_09]
        end
    end

    // ------------------------------------------------------------------------
    // Counter data ports and control word
    // ------------------------------------------------------------------------
    for (genvar k = 0; k < 3; k++) begin : g_ctr
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                ctr_wr[k] <= 1'b0;
                ctr_rd[k] <= 1'b0;
                ctr_wdata[k] <= 8'h00;
            end else begin
                ctr_wr[k] <= wr_ev && port_hit && (hit0[k] || (two && hit1[k]));
                ctr_rd[k] <= rd_ev && port_hit && (hit0[k] || (two && hit1[k]));
                if (wr_ev && port_hit && two && hit1[k]) begin
                    ctr_wdata[k] <= s3.wdata[15:8];
                end else if (wr_ev && port_hit && hit0[k]) begin
                    ctr_wdata[k] <= s3.wdata[7:0]; // [RULE_10]
                end
            end
        end

        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                counter_cfg[k] <= '0;
                ctr_cfg_load[k] <= 1'b0;
                ctr_latch[k] <= 1'b0;
            end else begin
                ctr_cfg_load[k] <= 1'b0;
                ctr_latch[k] <= 1'b0;
                if (wr_ev && cw_hit && cw_byte[7:6] == 2'(k)) begin // [RULE_13]
                    if (cw_byte[5:4] == ACC_LATCH) begin
                        ctr_latch[k] <= 1'b1; // [RULE_14]
                    end else begin
                        counter_cfg[k].access <= ctr_access_t'(cw_byte[5:4]); // [RULE_14]
                        counter_cfg[k].mode <= norm_mode(cw_byte[3:1]); // [RULE_15]
                        counter_cfg[k].bcd <= cw_byte[0]; // [RULE_16]
                        ctr_cfg_load[k] <= 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            readback_cmd <= 1'b0;
            readback_byte <= 8'h00;
        end else begin
            readback_cmd <= wr_ev && cw_hit && cw_byte[7:6] == 2'b11; // [RULE_13]
            if (wr_ev && cw_hit && cw_byte[7:6] == 2'b11) readback_byte <= cw_byte;
        end
    end

    // ------------------------------------------------------------------------
    // Indexed array and pointer
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (wr_ev && port_hit && active_bank_flag == BANK_INDEXED) begin
            if (mem_ok(idx0)) idx_mem[idx0[6:0]] <= s3.wdata[7:0];
            if (two && mem_ok(idx1)) idx_mem[idx1[6:0]] <= s3.wdata[15:8];
        end
    end

    // Each indexed-bank data port access advances the pointer by the bytes moved.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ptr <= `PTR_RST;
        end else if (wr_ev && ptr_hit) begin
            ptr <= s3.wdata[7:0];
        end else if ((rd_ev || wr_ev) && port_hit && active_bank_flag == BANK_INDEXED) begin
            ptr <= ptr + (two ? 8'h02 : 8'h01); // [RULE_17]
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 16'h0000;
            rdata_oe <= 1'b0;
        end else if (rd_ev && s3.addr >= `OFS_GAIN_CFG) begin
            rdata_oe <= 1'b1;
            if (s3.addr == `OFS_GAIN_CFG) begin
                rdata <= {8'h00, active_bank_flag, 3'b000, gain_cfg}; // [RULE_05] [RULE_07]
            end else if (ptr_hit) begin
                rdata <= {8'h00, ptr};
            end else if (port_hit) begin
                rdata <= {two ? byte_of(idx1) : 8'h00, byte_of(idx0)}; // [RULE_10]
            end else begin
                rdata <= 16'h0000;
            end
        end else if (rd_end) begin
            rdata_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_cfg_write_low: assert property ( // [RULE_06]
        cfg_wr |=> gain_cfg == $past(s3.wdata[3:0]))
        else $error("config write did not load range, unipolar and gain");
    a_cfg_read_map: assert property ( // [RULE_07]
        rd_ev && s3.addr == `OFS_GAIN_CFG
        |=> rdata[7] == $past(active_bank_flag) && rdata[6:4] == 3'b000
            && rdata[3:0] == $past(gain_cfg) && rdata_oe)
        else $error("config read pattern wrong");
    a_bank_keep: assert property ( // [RULE_03]
        cfg_wr && s3.wdata[7:4] != `KEY_IDX_3 && s3.wdata[7:4] != `KEY_CTR_3 && enh_lvl
        |=> $stable(active_bank_flag))
        else $error("bank changed on a non-final key");
    a_bank_enh: assert property ( // [RULE_05]
        !enh_lvl |=> active_bank_flag == BANK_COUNTER)
        else $error("indexed bank outside enhanced mode");
    a_span_widest: assert property ( // [RULE_08]
        gain_cfg.range |=> span == SPAN_BI_10)
        else $error("range bit did not give widest span");
    a_sample_code: assert property ( // [RULE_09]
        sample_valid |=> sample_code_valid
            && sample_code == {~$past(sample_raw[15]), $past(sample_raw[14:4])})
        else $error("sample code not offset binary");
    a_ctr_map: assert property ( // [RULE_10]
        wr_ev && active_bank_flag == BANK_COUNTER && s3.addr == `OFS_CTR0
        |=> ctr_wr == 3'b001 && ctr_wdata[0] == $past(s3.wdata[7:0]))
        else $error("offset C write missed counter 0");
    a_ctrl_wo: assert property ( // [RULE_11]
        rd_ev && active_bank_flag == BANK_COUNTER && s3.addr == `OFS_CTRL
        |=> rdata == 16'h0000 && ctr_rd == 3'b000)
        else $error("control word read not zero");
    a_index_alias: assert property ( // [RULE_12]
        wr_ev && active_bank_flag == BANK_INDEXED && s3.addr == `OFS_CTR0
            && s3.word_n && ptr == `IDX_CTR0
        |=> ctr_wr == 3'b001)
        else $error("index 68 did not reach counter 0");
    a_cw_decode: assert property ( // [RULE_13] [RULE_14] [RULE_16]
        wr_ev && cw_hit && cw_byte[7:6] == 2'b01 && cw_byte[5:4] != 2'b00
        |=> ctr_cfg_load == 3'b010 && counter_cfg[1].access == $past(cw_byte[5:4])
            && counter_cfg[1].bcd == $past(cw_byte[0]) && !readback_cmd)
        else $error("control word decode wrong for counter 1");
    a_cw_mode: assert property ( // [RULE_15]
        wr_ev && cw_hit && cw_byte[7:6] == 2'b00 && cw_byte[5:4] != 2'b00
            && cw_byte[2:1] == 2'b10
        |=> counter_cfg[0].mode == MODE_RATE)
        else $error("X10 did not select rate mode");
    a_cw_latch: assert property ( // [RULE_14]
        wr_ev && cw_hit && cw_byte[7:6] == 2'b01 && cw_byte[5:4] == 2'b00
        |=> ctr_latch == 3'b010 ##1 ctr_latch == 3'b000)
        else $error("latch command not a single pulse");
    a_word_port: assert property ( // [RULE_17]
        rd_ev && active_bank_flag == BANK_INDEXED && s3.addr == `OFS_CTR0 && !s3.word_n
        |=> ptr == $past(ptr) + 8'h02)
        else $error("word access did not advance pointer by two");

    c_word_read: cover property (rd_ev && two);
    c_readback: cover property (readback_cmd);
    c_alias_ctrl: cover property (ctr_cfg_load != 3'b000 && active_bank_flag == BANK_INDEXED);

endmodule // bank_regs

// [bank_regs_cfg.svh]
// Offsets, field positions, reset values and key codes of the banked registers.
`ifndef BANK_REGS_CFG_SVH
`define BANK_REGS_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_GAIN_CFG 4'hB
`define OFS_CTR0 4'hC
`define OFS_CTR1 4'hD
`define OFS_PTR 4'hE
`define OFS_CTRL 4'hF

// ----------------------------------------------------------------------------
// Indexed array
// ----------------------------------------------------------------------------
`define IDX_CTR0 8'h44
`define IDX_CTRL 8'h47
`define IDX_MEM_DEPTH 128
`define PTR_RST 8'h00

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CFG_KEY_HI 7
`define CFG_KEY_LO 4
`define CFG_LOW_HI 3
`define GAIN_CFG_RST 4'h0
`define PINS_IDLE 24'hE00000

// ----------------------------------------------------------------------------
// Bank key nibbles
// ----------------------------------------------------------------------------
`define KEY_IDX_1 4'hF
`define KEY_IDX_2 4'h5
`define KEY_IDX_3 4'hD
`define KEY_CTR_1 4'h3
`define KEY_CTR_2 4'hB
`define KEY_CTR_3 4'hA

`endif

// [bank_regs_pkg.sv]
// Types shared by the banked register logic.
package bank_regs_pkg;

    typedef enum logic {
        BANK_COUNTER = 1'b0,
        BANK_INDEXED = 1'b1
    } bank_t;

    typedef enum logic [2:0] {
        MODE_TC_INT = 3'b000,
        MODE_ONESHOT = 3'b001,
        MODE_RATE = 3'b010,
        MODE_SQUARE = 3'b011,
        MODE_SW_STROBE = 3'b100,
        MODE_HW_STROBE = 3'b101
    } ctr_mode_t;

    typedef enum logic [1:0] {
        ACC_LATCH = 2'b00,
        ACC_LOW = 2'b01,
        ACC_HIGH = 2'b10,
        ACC_LOW_HIGH = 2'b11
    } ctr_access_t;

    typedef struct packed {
        ctr_access_t access;
        ctr_mode_t mode;
        logic bcd;
    } ctr_cfg_t;

    typedef struct packed {
        logic range;
        logic unipolar_select;
        logic [1:0] gain_code;
    } gain_cfg_t;

    typedef enum logic [3:0] {
        SPAN_BI_10 = 4'h0,
        SPAN_BI_5 = 4'h1,
        SPAN_BI_2P5 = 4'h2,
        SPAN_BI_1P25 = 4'h3,
        SPAN_BI_0P625 = 4'h4,
        SPAN_UNI_10 = 4'h5,
        SPAN_UNI_5 = 4'h6,
        SPAN_UNI_2P5 = 4'h7,
        SPAN_UNI_1P25 = 4'h8
    } span_t;

    typedef enum logic [2:0] {
        KEY_IDLE = 3'b000,
        KEY_UP1 = 3'b001,
        KEY_UP2 = 3'b010,
        KEY_DN1 = 3'b011,
        KEY_DN2 = 3'b100
    } key_state_t;

    typedef struct packed {
        logic ior_n;
        logic iow_n;
        logic word_n;
        logic enhanced_mode;
        logic [3:0] addr;
        logic [15:0] wdata;
    } bus_pins_t;

endpackage

// [bank_key_detect.sv]
// Key sequence detector that selects the active register bank.
`timescale 1ns/1ns
`include "bank_regs_cfg.svh"
module bank_key_detect
    import bank_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic key_write,
    input wire logic [3:0] bank_key_nibble,
    output bank_t active_bank_flag
);

    key_state_t state;
    key_state_t next_state;

    // ------------------------------------------------------------------------
    // Sequence tracking
    // ------------------------------------------------------------------------
    always_comb begin
        if (bank_key_nibble == `KEY_IDX_1) begin
            next_state = KEY_UP1; // [RULE_18]
        end else if (bank_key_nibble == `KEY_CTR_1) begin
            next_state = KEY_DN1;
        end else begin
            next_state = KEY_IDLE; // [RULE_03]
        end
        case (state)
            KEY_UP1: if (bank_key_nibble == `KEY_IDX_2) next_state = KEY_UP2;
            KEY_DN1: if (bank_key_nibble == `KEY_CTR_2) next_state = KEY_DN2;
            default: ;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= KEY_IDLE;
        end else if (!enable) begin
            state <= KEY_IDLE;
        end else if (key_write) begin
            state <= next_state;
        end
    end

    // Leaving enhanced mode drops back to the original layout.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            active_bank_flag <= BANK_COUNTER; // [RULE_04]
        end else if (!enable) begin
            active_bank_flag <= BANK_COUNTER;
        end else if (key_write) begin
            if (state == KEY_UP2 && bank_key_nibble == `KEY_IDX_3) begin
                active_bank_flag <= BANK_INDEXED; // [RULE_01]
            end else if (state == KEY_DN2 && bank_key_nibble == `KEY_CTR_3) begin
                active_bank_flag <= BANK_COUNTER; // [RULE_02]
            end
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_key_to_index: assert property ( // [RULE_01]
        enable && key_write && state == KEY_UP2 && bank_key_nibble == `KEY_IDX_3
        |=> active_bank_flag == BANK_INDEXED && state == KEY_IDLE)
        else $error("index key did not select the indexed bank");
    a_key_to_ctr: assert property ( // [RULE_02]
        enable && key_write && state == KEY_DN2 && bank_key_nibble == `KEY_CTR_3
        |=> active_bank_flag == BANK_COUNTER)
        else $error("counter key did not select the counter bank");
    a_key_rise: assert property ( // [RULE_03]
        $rose(active_bank_flag) |-> $past(key_write) && $past(state) == KEY_UP2)
        else $error("bank changed without the full key");
    a_key_refirst: assert property ( // [RULE_18]
        enable && key_write && bank_key_nibble == `KEY_IDX_1 |=> state == KEY_UP1)
        else $error("repeated first key did not hold step one");
    a_reset_bank: assert property ( // [RULE_04]
        $rose(resetn) |-> active_bank_flag == BANK_COUNTER)
        else $error("bank not counter after reset");
    c_enter_index: cover property ($rose(active_bank_flag));
    c_leave_index: cover property ($fell(active_bank_flag));

endmodule // bank_key_detect

// [host_bus.sv]
// Host processor model that drives the register strobes, address and write data.
`timescale 1ns/1ns
module host_bus (
    input wire logic mclk,
    input wire logic [15:0] rdata,
    output logic ior_n,
    output logic iow_n,
    output logic word_n,
    output logic [3:0] addr,
    output logic [15:0] wdata
);
    initial begin
        {ior_n, iow_n, word_n} = 3'b111;
        addr = 4'h0;
        wdata = 16'h0000;
    end
    // Address settles three cycles before the strobe; data is inverted when released.
    task xfer(input logic wr, input logic [3:0] a, input logic [15:0] d, input logic w16,
        output logic [15:0] q);
        @(negedge mclk);
        addr = a;
        wdata = wr ? d : ~wdata;
        word_n = ~w16;
        repeat (3) @(negedge mclk);
        if (wr) iow_n = 1'b0;
        else ior_n = 1'b0;
        repeat (5) @(negedge mclk);
        q = rdata;
        {ior_n, iow_n} = 2'b11;
        wdata = ~wdata;
        repeat (4) @(negedge mclk);
    endtask
endmodule // host_bus

// [tb_top.sv]
// Self-checking bench for the banked gain and counter registers.
`timescale 1ns/1ns
module tb_top;
    import bank_regs_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic enh = 1'b1;
    logic sv = 1'b0;
    logic ls = 1'b0;
    logic ior_n, iow_n, word_n;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, q;
    logic [15:0] raw = 16'h8010;
    logic [2:0][7:0] crb = {8'h33, 8'h22, 8'h11};
    logic [2:0][7:0] cwd;
    logic [11:0] code;
    logic [2:0] lat;
    logic [7:0] rbb;
    gain_cfg_t gcf;
    span_t span;
    bank_t bank;
    ctr_cfg_t [2:0] ccfg;
    int miscompares = 0;
    int tests_run = 0;
    logic [7:0] grow [9] = '{8'h80, 8'h01, 8'h12, 8'h23, 8'h34, 8'h45, 8'h56, 8'h67, 8'h78};
    logic [15:0] crow [8] = '{16'h1B1B, 16'h6C64, 16'hB9B9, 16'h3030, 16'h5353, 16'hAFA7,
        16'h1616, 16'h3434};
    host_bus host (.mclk(mclk), .rdata(rdata), .ior_n(ior_n), .iow_n(iow_n), .word_n(word_n),
        .addr(addr), .wdata(wdata));
    bank_regs dut (.mclk(mclk), .resetn(resetn), .ior_n(ior_n), .iow_n(iow_n), .word_n(word_n),
        .enhanced_mode(enh), .addr(addr), .wdata(wdata), .rdata(rdata), .rdata_oe(),
        .ctr_rd_byte(crb), .sample_raw(raw), .sample_valid(sv), .sample_code(code),
        .sample_code_valid(), .gain_cfg(gcf), .span(span), .active_bank_flag(bank),
        .counter_cfg(ccfg), .ctr_cfg_load(), .ctr_latch(lat), .readback_cmd(),
        .readback_byte(rbb), .ctr_wr(), .ctr_wdata(cwd), .ctr_rd());
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) if (lat[1]) ls <= 1'b1;
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {8'h00, d}, 1'b0, q);
    endtask
    task rd(input logic [3:0] a);
        host.xfer(1'b0, a, 16'h0000, 1'b0, q);
    endtask
    task keys(input logic [11:0] k);
        for (int i = 0; i < 3; i++) wr(4'hB, {k[11-4*i -: 4], 4'h0});
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        end_sim;
    end
    initial begin
        repeat (20) @(negedge mclk);
        chk("bank", 16'h0000, 16'(bank));
        chk("span", 16'(SPAN_BI_5), 16'(span));
        resetn = 1'b1;
        for (int i = 0; i < 9; i++) begin
            wr(4'hB, {4'h0, grow[i][7:4]});
            chk("gain", 16'(grow[i][7:4]), 16'(gcf));
            chk("span", 16'(grow[i][3:0]), 16'(span));
            rd(4'hB);
            chk("cfg read", 16'(grow[i][7:4]), q);
        end
        for (int i = 0; i < 8; i++) begin
            wr(4'hF, crow[i][15:8]);
            chk("ccfg", 16'(crow[i][5:0]), 16'(ccfg[crow[i][7:6]]));
        end
        wr(4'hF, 8'h40);
        chk("latch", 16'h0001, 16'(ls));
        chk("ccfg1", 16'h0013, 16'(ccfg[1]));
        wr(4'hF, 8'hE2);
        chk("readback", 16'h00E2, 16'(rbb));
        rd(4'hF);
        chk("ctrl read", 16'h0000, q);
        wr(4'hC, 8'h5A);
        chk("ctr0 wdata", 16'h005A, 16'(cwd[0]));
        wr(4'hE, 8'hA5);
        chk("ctr2 wdata", 16'h00A5, 16'(cwd[2]));
        rd(4'hD);
        chk("ctr1 read", 16'h0022, 16'(q[7:0]));
        @(negedge mclk) sv = 1'b1;
        @(negedge mclk) sv = 1'b0;
        repeat (3) @(negedge mclk);
        chk("code", 16'h0001, 16'(code));
        enh = 1'b0;
        keys(12'hF5D);
        chk("bank off", 16'h0000, 16'(bank));
        enh = 1'b1;
        keys(12'hF7D);
        keys(12'hF5A);
        chk("bank other", 16'h0000, 16'(bank));
        wr(4'hB, 8'hF0);
        keys(12'hF5D);
        chk("bank idx", 16'h0001, 16'(bank));
        rd(4'hB);
        chk("bank bit", 16'h0001, 16'(q[7]));
        wr(4'hE, 8'h44);
        wr(4'hC, 8'h6B);
        chk("idx 68 wdata", 16'h006B, 16'(cwd[0]));
        wr(4'hE, 8'h44);
        rd(4'hC);
        chk("idx 68", 16'h0011, 16'(q[7:0]));
        rd(4'hD);
        chk("idx 70", 16'h0033, 16'(q[7:0]));
        wr(4'hE, 8'h47);
        wr(4'hC, 8'h54);
        chk("idx 71 ccfg1", 16'h0014, 16'(ccfg[1]));
        wr(4'hE, 8'h00);
        host.xfer(1'b1, 4'hC, 16'hBEEF, 1'b1, q);
        wr(4'hE, 8'h00);
        host.xfer(1'b0, 4'hC, 16'h0000, 1'b1, q);
        chk("word", 16'hBEEF, q);
        rd(4'hE);
        chk("pointer", 16'h0002, 16'(q[7:0]));
        keys(12'h3BA);
        chk("bank ctr", 16'h0000, 16'(bank));
        keys(12'hF5D);
        resetn = 1'b0;
        @(negedge mclk);
        chk("bank rst", 16'h0000, 16'(bank));
        chk("gain rst", 16'h0000, 16'(gcf));
        resetn = 1'b1;
        end_sim;
    end
endmodule // tb_top
